// ===== interrupt_vector_selector_regs.svh
// Register offsets, field positions, reset values and table constants of the vector selector
`ifndef INTERRUPT_VECTOR_SELECTOR_REGS_SVH
`define INTERRUPT_VECTOR_SELECTOR_REGS_SVH

// -------------------------------------------------------------
// Register byte offsets
// -------------------------------------------------------------
`define IVS_FLAG_BASE 8'h00
`define IVS_ENABLE_BASE 8'h20
`define IVS_PRIO_BASE 8'h40
`define IVS_CTRL_TWO_OFS 8'hc0
`define IVS_TRAP_STAT_OFS 8'hc4
`define IVS_WIN_STAT_OFS 8'hc8
`define IVS_FLAG_WORDS 6
`define IVS_PRIO_WORDS 22

// -------------------------------------------------------------
// Field positions and reset values
// -------------------------------------------------------------
`define IVS_ALT_SEL_BIT 15
`define IVS_WIN_LEVEL_LSB 8
`define IVS_PRIO_FIELD_STEP 4
`define IVS_CTRL_TWO_RESET 32'h0000_0000
`define IVS_ZERO_WORD 32'h0000_0000

// -------------------------------------------------------------
// Vector table layout
// -------------------------------------------------------------
`define IVS_PRIMARY_BASE 24'h000004
`define IVS_ALT_DISTANCE 24'h000100
`define IVS_RESET_ADDR 24'h000000
`define IVS_NUM_TRAPS 8
`define IVS_NUM_IRQ 87
`define IVS_USER_MAX_LEVEL 4'h7
`define IVS_TRAP_TOP_LEVEL 4'hf

`endif

// ===== interrupt_vector_selector_pkg.sv
// Types shared by the vector selector and its bench
package interrupt_vector_selector_pkg;

  // APB request from the master
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } apb_req_t;

  // APB answer from the slave
  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } apb_rsp_t;

  // Request offered to the CPU core
  typedef struct packed {
    logic valid;
    logic [6:0] vector;
    logic [3:0] level;
    logic [23:0] handler;
  } cpu_req_t;

  // Entry sequence states, one-hot
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_FETCH = 4'b0010,
    ST_LOAD = 4'b0100,
    ST_OFFER = 4'b1000
  } entry_state_t;

endpackage

// ===== interrupt_vector_selector.sv
// Interrupt vector selector: flag, enable and priority store, arbiter and vector fetch
//
// The placing of the registers and the APB slave port were chosen for this implementation.
`timescale 1ns/100ps
`include "interrupt_vector_selector_regs.svh"

module interrupt_vector_selector
  import interrupt_vector_selector_pkg::*;
(
  input wire logic I_CLOCK,
  input wire logic I_RSTN,
  input wire apb_req_t I_APB,
  output apb_rsp_t O_APB,
  input wire logic [86:0] I_IRQ_LINES,
  input wire logic [7:0] I_TRAP_EVENTS,
  input wire logic [3:0] I_CPU_PRIORITY_LEVEL,
  output logic O_FETCH_REQ,
  output logic [23:0] O_FETCH_ADDR,
  input wire logic [23:0] I_FETCH_DATA,
  output cpu_req_t O_CPU_REQ,
  input wire logic I_CPU_ACK
);

  // -------------------------------------------------------------
  // Storage
  // -------------------------------------------------------------
  logic [95:0] pending_flag_reg; // Pending flags, 16 per word
  logic [95:0] source_enable_reg; // Enables, 16 per word
  logic [2:0] source_prio_reg [0:`IVS_NUM_IRQ-1]; // Per source level
  logic alt_table_select_reg; // Alternate table in use
  logic [7:0] trap_flag_reg; // Sticky trap status
  logic [6:0] win_vector_reg; // Last accepted vector
  logic [3:0] win_level_reg; // Last accepted level
  apb_rsp_t apb_rsp_reg; // Registered bus answer
  entry_state_t state_reg; // Entry sequence state
  cpu_req_t cpu_req_reg; // Request toward the core
  logic fetch_req_reg; // Table read strobe
  logic [23:0] fetch_addr_reg; // Table read address

  // -------------------------------------------------------------
  // Bus decode
  // -------------------------------------------------------------
  logic setup_phase; // First cycle of a transfer
  logic write_commit; // Access edge of a write
  logic [7:0] word_ofs; // Byte address of the word
  assign setup_phase = I_APB.psel && !I_APB.penable;
  assign write_commit = I_APB.psel && I_APB.penable && apb_rsp_reg.pready && I_APB.pwrite;
  assign word_ofs = {I_APB.paddr[7:2], 2'b00};

  logic [2:0] flag_idx; // Flag or enable word index
  logic hit_flag;
  logic hit_enable;
  logic hit_prio;
  assign flag_idx = word_ofs[4:2];
  assign hit_flag = (word_ofs >= `IVS_FLAG_BASE) &&
                    (word_ofs < `IVS_FLAG_BASE + 8'(4 * `IVS_FLAG_WORDS));
  assign hit_enable = (word_ofs >= `IVS_ENABLE_BASE) &&
                      (word_ofs < `IVS_ENABLE_BASE + 8'(4 * `IVS_FLAG_WORDS));
  assign hit_prio = (word_ofs >= `IVS_PRIO_BASE) &&
                    (word_ofs < `IVS_PRIO_BASE + 8'(4 * `IVS_PRIO_WORDS));

  logic [4:0] prio_word_idx; // Priority word index from offset
  assign prio_word_idx = 5'((word_ofs - `IVS_PRIO_BASE) >> 2);

  // -------------------------------------------------------------
  // Per-source eligibility and priority word images
  // -------------------------------------------------------------
  logic [`IVS_NUM_IRQ-1:0] eligible; // Flag, enable and level all pass
  logic [31:0] prio_word [0:`IVS_PRIO_WORDS-1]; // Readback images
  logic user_open; // CPU level leaves room for users
  assign user_open = I_CPU_PRIORITY_LEVEL < `IVS_USER_MAX_LEVEL;

  genvar gi;
  generate
    for (gi = 0; gi < `IVS_NUM_IRQ; gi = gi + 1) begin : g_src
      // Field n sits in word n/16 bit n%16 and in prio word n/4
      assign eligible[gi] = pending_flag_reg[gi] && source_enable_reg[gi] &&
                            user_open &&
                            ({1'b0, source_prio_reg[gi]} > I_CPU_PRIORITY_LEVEL);
    end
    for (gi = 0; gi < `IVS_PRIO_WORDS; gi = gi + 1) begin : g_pword
      // Three-bit fields at bit 4k; the field past source 86 in word 21 reads zero
      always_comb begin
        prio_word[gi] = `IVS_ZERO_WORD;
        for (int k = 0; k < 4; k++) begin
          if (4 * gi + k < `IVS_NUM_IRQ) begin
            prio_word[gi][4*k +: 3] = source_prio_reg[4*gi+k];
          end
        end
      end
    end
  endgenerate

  // -------------------------------------------------------------
  // Arbiter: traps first, then level, then natural order
  // -------------------------------------------------------------
  logic any_win; // Something may be forwarded
  logic [6:0] best_vector; // Table index, traps 0-7 then 8+n
  logic [3:0] best_level; // Level the CPU will take on

  always_comb begin
    any_win = 1'b0;
    best_vector = 7'h00;
    best_level = 4'h0;
    // Walk downward so the lowest number wins a tie
    for (int n = `IVS_NUM_IRQ - 1; n >= 0; n--) begin
      if (eligible[n] && (!any_win || {1'b0, source_prio_reg[n]} >= best_level)) begin
        any_win = 1'b1;
        best_vector = 7'(n + `IVS_NUM_TRAPS);
        best_level = {1'b0, source_prio_reg[n]};
      end
    end
    // Traps outrank users; level 15-n keeps them above any user
    for (int t = `IVS_NUM_TRAPS - 1; t >= 0; t--) begin
      if (trap_flag_reg[t] &&
          (`IVS_TRAP_TOP_LEVEL - 4'(t)) > I_CPU_PRIORITY_LEVEL) begin
        any_win = 1'b1;
        best_vector = 7'(t);
        best_level = `IVS_TRAP_TOP_LEVEL - 4'(t);
      end
    end
  end

  // Entry address: base + 2*index, plus 0x100 in the alternate table
  logic [23:0] entry_addr;
  always_comb begin
    entry_addr = `IVS_PRIMARY_BASE + {16'h0000, best_vector, 1'b0};
    if (alt_table_select_reg) begin
      entry_addr = entry_addr + `IVS_ALT_DISTANCE;
    end
  end

  // -------------------------------------------------------------
  // Register writes
  // -------------------------------------------------------------
  // Pending flags: hardware set beats a software clear in the same cycle
  always_ff @(posedge I_CLOCK) begin
    if (!I_RSTN) begin
      pending_flag_reg <= 96'h0;
    end else begin
      for (int w = 0; w < `IVS_FLAG_WORDS; w++) begin
        for (int b = 0; b < 16; b++) begin
          if (16 * w + b < `IVS_NUM_IRQ) begin
            if (I_IRQ_LINES[16*w+b]) begin
              pending_flag_reg[16*w+b] <= 1'b1;
            end else if (write_commit && hit_flag && flag_idx == 3'(w)) begin
              pending_flag_reg[16*w+b] <= I_APB.pwdata[b];
            end
          end
        end
      end
    end
  end

  // Enables, one word at a time
  always_ff @(posedge I_CLOCK) begin
    if (!I_RSTN) begin
      source_enable_reg <= 96'h0;
    end else if (write_commit && hit_enable) begin
      for (int w = 0; w < `IVS_FLAG_WORDS; w++) begin
        if (flag_idx == 3'(w)) begin
          for (int b = 0; b < 16; b++) begin
            if (16 * w + b < `IVS_NUM_IRQ) begin
              source_enable_reg[16*w+b] <= I_APB.pwdata[b];
            end
          end
        end
      end
    end
  end

  // Priority fields, four to a word
  always_ff @(posedge I_CLOCK) begin
    if (!I_RSTN) begin
      for (int n = 0; n < `IVS_NUM_IRQ; n++) begin
        source_prio_reg[n] <= 3'h0;
      end
    end else if (write_commit && hit_prio) begin
      for (int n = 0; n < `IVS_NUM_IRQ; n++) begin
        if (prio_word_idx == 5'(n / 4)) begin
          source_prio_reg[n] <= I_APB.pwdata[`IVS_PRIO_FIELD_STEP*(n%4) +: 3];
        end
      end
    end
  end

  // Table select in the second control word
  always_ff @(posedge I_CLOCK) begin
    if (!I_RSTN) begin
      alt_table_select_reg <= 1'b0;
    end else if (write_commit && word_ofs == `IVS_CTRL_TWO_OFS) begin
      alt_table_select_reg <= I_APB.pwdata[`IVS_ALT_SEL_BIT];
    end
  end

  // Trap status: only sources 1-4 exist, set beats clear
  always_ff @(posedge I_CLOCK) begin
    if (!I_RSTN) begin
      trap_flag_reg <= 8'h00;
    end else begin
      for (int t = 1; t <= 4; t++) begin
        if (I_TRAP_EVENTS[t]) begin
          trap_flag_reg[t] <= 1'b1;
        end else if (write_commit && word_ofs == `IVS_TRAP_STAT_OFS) begin
          trap_flag_reg[t] <= I_APB.pwdata[t];
        end
      end
    end
  end

  // -------------------------------------------------------------
  // Bus answer: data prepared in setup, ready in access
  // -------------------------------------------------------------
  always_ff @(posedge I_CLOCK) begin
    if (!I_RSTN) begin
      apb_rsp_reg <= '0;
    end else if (setup_phase) begin
      apb_rsp_reg.pready <= 1'b1;
      apb_rsp_reg.pslverr <= 1'b0;
      apb_rsp_reg.prdata <= `IVS_ZERO_WORD;
      if (hit_flag) begin
        apb_rsp_reg.prdata <= {16'h0000, pending_flag_reg[16*flag_idx +: 16]};
      end else if (hit_enable) begin
        apb_rsp_reg.prdata <= {16'h0000, source_enable_reg[16*flag_idx +: 16]};
      end else if (hit_prio) begin
        apb_rsp_reg.prdata <= prio_word[prio_word_idx];
      end else if (word_ofs == `IVS_CTRL_TWO_OFS) begin
        apb_rsp_reg.prdata[`IVS_ALT_SEL_BIT] <= alt_table_select_reg;
      end else if (word_ofs == `IVS_TRAP_STAT_OFS) begin
        apb_rsp_reg.prdata <= {24'h000000, trap_flag_reg};
      end else if (word_ofs == `IVS_WIN_STAT_OFS) begin
        apb_rsp_reg.prdata <= {20'h00000, win_level_reg, 1'b0, win_vector_reg};
      end else begin
        apb_rsp_reg.pslverr <= 1'b1; // Unmapped offset
      end
    end else begin
      // One access cycle per transfer, then idle
      apb_rsp_reg.pready <= 1'b0;
      apb_rsp_reg.pslverr <= 1'b0;
    end
  end

  // -------------------------------------------------------------
  // Entry sequence: fixed three cycles to the offer
  // -------------------------------------------------------------
  // The winner is frozen in IDLE so a later arrival cannot stretch entry
  always_ff @(posedge I_CLOCK) begin
    if (!I_RSTN) begin
      state_reg <= ST_IDLE;
      cpu_req_reg <= '0; // Handler reads zero: core starts at 000000h
      fetch_req_reg <= 1'b0;
      fetch_addr_reg <= `IVS_RESET_ADDR;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          if (any_win) begin
            cpu_req_reg.vector <= best_vector;
            cpu_req_reg.level <= best_level;
            fetch_addr_reg <= entry_addr;
            fetch_req_reg <= 1'b1;
            state_reg <= ST_FETCH;
          end
        end
        ST_FETCH: begin
          // Memory answers one cycle after the strobe
          fetch_req_reg <= 1'b0;
          state_reg <= ST_LOAD;
        end
        ST_LOAD: begin
          cpu_req_reg.handler <= I_FETCH_DATA;
          cpu_req_reg.valid <= 1'b1;
          state_reg <= ST_OFFER;
        end
        ST_OFFER: begin
          if (I_CPU_ACK) begin
            cpu_req_reg.valid <= 1'b0;
            state_reg <= ST_IDLE;
          end
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // Status latch on the accepting edge
  always_ff @(posedge I_CLOCK) begin
    if (!I_RSTN) begin
      win_vector_reg <= 7'h00;
      win_level_reg <= 4'h0;
    end else if (state_reg == ST_OFFER && I_CPU_ACK) begin
      win_vector_reg <= cpu_req_reg.vector;
      win_level_reg <= cpu_req_reg.level;
    end
  end

  // -------------------------------------------------------------
  // Outputs, all from flip-flops
  // -------------------------------------------------------------
  assign O_APB = apb_rsp_reg;
  assign O_CPU_REQ = cpu_req_reg;
  assign O_FETCH_REQ = fetch_req_reg;
  assign O_FETCH_ADDR = fetch_addr_reg;

endmodule

// ===== interrupt_vector_selector_assertions.sv
// Port-level checker of the interrupt vector selector
`timescale 1ns/100ps
module ivs_checker
  import interrupt_vector_selector_pkg::*;
(
  input wire logic I_CLOCK,
  input wire logic I_RSTN,
  input wire apb_req_t I_APB,
  input wire apb_rsp_t O_APB,
  input wire logic [86:0] I_IRQ_LINES,
  input wire logic [7:0] I_TRAP_EVENTS,
  input wire logic [3:0] I_CPU_PRIORITY_LEVEL,
  input wire logic O_FETCH_REQ,
  input wire logic [23:0] O_FETCH_ADDR,
  input wire logic [23:0] I_FETCH_DATA,
  input wire cpu_req_t O_CPU_REQ,
  input wire logic I_CPU_ACK
);
  // ----------------------------------------
  // Clocking and shorthands
  // ----------------------------------------
  default clocking @(posedge I_CLOCK); endclocking
  default disable iff (!I_RSTN);
  logic v; // Request valid toward the core
  logic [23:0] off; // Twice the vector index, as a byte offset
  assign v = O_CPU_REQ.valid;
  assign off = {16'h0, O_CPU_REQ.vector, 1'b0};
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  a_reset_start: assert property (disable iff (1'b0) !I_RSTN |=> !v && O_CPU_REQ.handler == 24'h0)
    else $error("outputs not cleared by reset");
  a_fetch_one_pulse: assert property (O_FETCH_REQ |=> !O_FETCH_REQ)
    else $error("fetch request longer than one cycle");
  a_fixed_entry_time: assert property (O_FETCH_REQ |-> ##2 v)
    else $error("entry latency not fixed");
  a_handler_from_table: assert property ($rose(v) |-> O_CPU_REQ.handler == $past(I_FETCH_DATA))
    else $error("handler differs from fetched entry");
  a_entry_address: assert property ($rose(v) |->
      O_FETCH_ADDR == 24'h4 + off || O_FETCH_ADDR == 24'h104 + off)
    else $error("fetch address not at vector entry");
  a_level_per_kind: assert property ($rose(v) |-> (O_CPU_REQ.vector < 7'd8) ?
      (O_CPU_REQ.level == 4'hf - O_CPU_REQ.vector[3:0]) : (O_CPU_REQ.level inside {[1:7]}))
    else $error("level does not fit source kind");
  a_user_above_cpu: assert property ($rose(v) && O_CPU_REQ.vector >= 7'd8 |->
      O_CPU_REQ.level > $past(I_CPU_PRIORITY_LEVEL, 3) && $past(I_CPU_PRIORITY_LEVEL, 3) < 4'h7)
    else $error("user request not above cpu level");
  a_request_holds: assert property (v && !I_CPU_ACK |=> v && $stable(O_CPU_REQ))
    else $error("request changed before acknowledge");
  a_request_drops: assert property (v && I_CPU_ACK |=> !v)
    else $error("request stayed after acknowledge");
  a_frozen_in_flight: assert property (v |-> !O_FETCH_REQ)
    else $error("fetch while request in flight");
  a_apb_zero_wait: assert property (I_APB.psel && !I_APB.penable |=> O_APB.pready)
    else $error("pready missing in access cycle");
  // Main scenarios reached
  c_trap_entry: cover property ($rose(v) && O_CPU_REQ.vector < 7'd8);
  c_alt_entry: cover property ($rose(v) && O_FETCH_ADDR[8]);
  c_slow_ack: cover property (v && !I_CPU_ACK ##1 v && I_CPU_ACK);
endmodule

bind interrupt_vector_selector ivs_checker u_chk (.I_CLOCK(I_CLOCK), .I_RSTN(I_RSTN),
  .I_APB(I_APB), .O_APB(O_APB), .I_IRQ_LINES(I_IRQ_LINES), .I_TRAP_EVENTS(I_TRAP_EVENTS),
  .I_CPU_PRIORITY_LEVEL(I_CPU_PRIORITY_LEVEL), .O_FETCH_REQ(O_FETCH_REQ),
  .O_FETCH_ADDR(O_FETCH_ADDR), .I_FETCH_DATA(I_FETCH_DATA), .O_CPU_REQ(O_CPU_REQ),
  .I_CPU_ACK(I_CPU_ACK));

// ===== cpu_core_model.sv
// Model of the CPU core and its vector table memory
`timescale 1ns/100ps
module cpu_core_model
  import interrupt_vector_selector_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_rstn,
  input wire logic i_fetch_req,
  input wire logic [23:0] i_fetch_addr,
  input wire cpu_req_t i_cpu_req,
  input wire logic [3:0] i_ack_delay,
  input wire logic i_level_wr,
  input wire logic [3:0] i_level_val,
  output logic [23:0] o_fetch_data,
  output logic o_cpu_ack,
  output logic [3:0] o_level
);
  logic [3:0] wait_reg; // Cycles the request has stood
  // Table answers one cycle after the fetch; otherwise the bus toggles so stale data shows
  always_ff @(posedge i_clock) begin
    if (!i_rstn) o_fetch_data <= 24'h0;
    else if (i_fetch_req) o_fetch_data <= i_fetch_addr ^ 24'h3c0000;
    else o_fetch_data <= ~o_fetch_data;
  end
  // Acknowledge after a chosen delay, so both quick and slow cores are seen
  always_ff @(posedge i_clock) begin
    if (!i_rstn || !i_cpu_req.valid) wait_reg <= 4'h0;
    else if (wait_reg != 4'hf) wait_reg <= wait_reg + 4'h1;
  end
  assign o_cpu_ack = i_cpu_req.valid && (wait_reg >= i_ack_delay);
  // Core raises its level on accept so the same source is not taken twice
  always_ff @(posedge i_clock) begin
    if (!i_rstn) o_level <= 4'h0;
    else if (o_cpu_ack) o_level <= i_cpu_req.level;
    else if (i_level_wr) o_level <= i_level_val;
  end
endmodule

// ===== interrupt_vector_selector_test.sv
// Self-checking bench of the interrupt vector selector
`timescale 1ns/100ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin n_mismatch++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, a, b); end end
module interrupt_vector_selector_test
  import interrupt_vector_selector_pkg::*;
;
  logic clk, rstn, err, lwr, ack, freq;
  apb_req_t apb;
  apb_rsp_t arsp;
  cpu_req_t creq;
  logic [86:0] irq;
  logic [7:0] trap;
  logic [3:0] lvl_now, dly, lval;
  logic [23:0] fa, fd;
  logic [31:0] q;
  int n_mismatch = 0;
  int comparisons = 0;
  interrupt_vector_selector u_dut (.I_CLOCK(clk), .I_RSTN(rstn), .I_APB(apb), .O_APB(arsp),
    .I_IRQ_LINES(irq), .I_TRAP_EVENTS(trap), .I_CPU_PRIORITY_LEVEL(lvl_now),
    .O_FETCH_REQ(freq), .O_FETCH_ADDR(fa), .I_FETCH_DATA(fd), .O_CPU_REQ(creq), .I_CPU_ACK(ack));
  cpu_core_model u_core (.i_clock(clk), .i_rstn(rstn), .i_fetch_req(freq), .i_fetch_addr(fa),
    .i_cpu_req(creq), .i_ack_delay(dly), .i_level_wr(lwr), .i_level_val(lval),
    .o_fetch_data(fd), .o_cpu_ack(ack), .o_level(lvl_now));
  always #5 clk = ~clk;
  // ----------------------------------------
  // Bus and stimulus tasks
  // ----------------------------------------
  // One APB transfer; waits for pready, bounded
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    apb <= '{1'b1, 1'b0, wr, a, d};
    @(posedge clk);
    apb.penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (arsp.pready !== 1'b1 && n < 20);
    // A transfer that never got its ready counts against the run
    if (arsp.pready !== 1'b1) n_mismatch++;
    q = arsp.prdata;
    err = arsp.pslverr;
    apb <= '0;
  endtask
  task automatic pulse(input logic [86:0] l, input logic [7:0] t);
    @(posedge clk);
    irq <= l;
    trap <= t;
    @(posedge clk);
    irq <= '0;
    trap <= '0;
  endtask
  task automatic lvl(input logic [3:0] v);
    @(posedge clk);
    lwr <= 1'b1;
    lval <= v;
    @(posedge clk);
    lwr <= 1'b0;
  endtask
  // Enable source n at priority p, then let its line set the flag
  task automatic arm(input int n, input logic [2:0] p);
    xfer(1'b1, 8'(32 + 4 * (n / 16)), 32'h1 << (n % 16));
    xfer(1'b1, 8'(64 + 4 * (n / 4)), 32'(p) << (4 * (n % 4)));
    pulse(87'h1 << n, 8'h0);
  endtask
  task automatic clear_all();
    for (int i = 0; i < 6; i++) begin
      xfer(1'b1, 8'(4 * i), 32'h0);
      xfer(1'b1, 8'(32 + 4 * i), 32'h0);
    end
    xfer(1'b1, 8'hc4, 32'h0);
    lvl(4'h0);
  endtask
  // Wait for one entry, check it and the status word, then tidy up
  task automatic entry(input logic [6:0] v, input logic [3:0] l, input logic [23:0] a);
    int n;
    n = 0;
    while (creq.valid !== 1'b1 && n < 50) begin
      @(posedge clk);
      n++;
    end
    `CHK(creq.valid, 1'b1)
    `CHK(creq.vector, v)
    `CHK(creq.level, l)
    `CHK(fa, a)
    `CHK(creq.handler, a ^ 24'h3c0000)
    while (creq.valid === 1'b1 && n < 80) begin
      @(posedge clk);
      n++;
    end
    `CHK(creq.valid, 1'b0)
    xfer(1'b0, 8'hc8, 32'h0);
    `CHK(q, {20'h0, l, 1'b0, v})
    clear_all();
  endtask
  task automatic report_and_stop();
    $display("comparisons=%0d n_mismatch=%0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // ----------------------------------------
  // Test sequence
  // ----------------------------------------
  initial begin
    clk = 0; rstn = 0; apb = '0; irq = '0; trap = '0; dly = 4'h0; lwr = 0; lval = 4'h0;
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    `CHK(creq.handler, 24'h0)
    xfer(1'b0, 8'hc0, 32'h0);
    `CHK(q, 32'h0)
    xfer(1'b0, 8'hfc, 32'h0);
    `CHK(err, 1'b1)
    $display("test reset done");
    pulse(87'h1 << 40, 8'h0);
    xfer(1'b0, 8'h08, 32'h0);
    `CHK(q, 32'h100)
    xfer(1'b1, 8'h08, 32'h0);
    xfer(1'b0, 8'h08, 32'h0);
    `CHK(q, 32'h0)
    $display("test flags done");
    // CPU level 7 holds both sources back so that they compete at one edge
    lvl(4'h7); arm(5, 3'd3); arm(40, 3'd6);
    lvl(4'h0); entry(7'd48, 4'h6, 24'h64);
    lvl(4'h7); arm(3, 3'd4); arm(20, 3'd4);
    lvl(4'h0); entry(7'd11, 4'h4, 24'h1a);
    dly <= 4'h3;
    arm(86, 3'd7); entry(7'd94, 4'h7, 24'hc0);
    $display("test arbitration done");
    lvl(4'h7); arm(0, 3'd7); repeat (20) @(posedge clk);
    `CHK(creq.valid, 1'b0)
    // Lower the priority while level 7 still masks it, then drop the CPU level
    arm(0, 3'd5); lvl(4'h5); repeat (20) @(posedge clk);
    `CHK(creq.valid, 1'b0)
    lvl(4'h4); entry(7'd8, 4'h5, 24'h14);
    $display("test masking done");
    xfer(1'b1, 8'hc0, 32'h8000);
    arm(0, 3'd1); entry(7'd8, 4'h1, 24'h114);
    pulse(87'h0, 8'h04); entry(7'd2, 4'hd, 24'h108);
    xfer(1'b1, 8'hc0, 32'h0);
    lvl(4'hf); arm(0, 3'd7); pulse(87'h0, 8'h10);
    lvl(4'h0); entry(7'd4, 4'hb, 24'h0c);
    $display("test traps done");
    report_and_stop();
  end
  // Hang guard: the sequence needs far fewer cycles than this
  initial begin
    repeat (30000) @(posedge clk);
    n_mismatch++;
    report_and_stop();
  end
endmodule
